// *** hw/sswc_pkg.sv ***
// Constants, register map and field layout of the supply supervisor wakeup control block.
// Assumes a 10 MHz pclk and an APB master with 32-bit data.
package sswc_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SLOW_US = 150;
    localparam int unsigned FAST_US = 2;
    localparam int unsigned FASTCLK_US = 6;
    localparam logic [15:0] SLOW_CYC = 16'(SLOW_US * (CLK_HZ / 1_000_000));
    localparam logic [15:0] FAST_CYC = 16'(FAST_US * (CLK_HZ / 1_000_000));
    localparam logic [15:0] FASTCLK_CYC = 16'(FASTCLK_US * (CLK_HZ / 1_000_000));
    // Register byte offsets.
    localparam logic [7:0] LOW_CTL_ADDR = 8'h00;
    localparam logic [7:0] HIGH_CTL_ADDR = 8'h04;
    localparam logic [7:0] FLAG_ADDR = 8'h08;
    localparam logic [7:0] CLKDIV_ADDR = 8'h0c;
    localparam logic [7:0] CLKREQ_ADDR = 8'h10;
    localparam logic [7:0] STATE_ADDR = 8'h14;
    // Low-side control fields.
    localparam int LS_SUP_EN = 0;
    localparam int LS_SUP_FP = 1;
    localparam int LS_SUP_RET = 2;
    localparam int LS_MON_EN = 3;
    localparam int LS_MON_FP = 4;
    localparam int LS_AUTO = 5;
    // High-side control fields.
    localparam int HS_SUP_EN = 0;
    localparam int HS_SUP_FP = 1;
    localparam int HS_SUP_RET = 2;
    localparam int HS_MON_EN = 3;
    localparam int HS_MON_FP = 4;
    localparam int HS_AUTO = 5;
    localparam int HS_OVP = 6;
    // Flag fields.
    localparam int FL_LOW_DLY = 0;
    localparam int FL_HIGH_DLY = 1;
    localparam int FL_WAKE_SLOW = 2;
    localparam int FL_POR = 3;
    // Clock divider field position and half-rate code.
    localparam int DIVM_LSB = 0;
    localparam logic [2:0] DIVM_HALF = 3'h1;
    localparam logic [5:0] LOW_CTL_RST = 6'h0d;
    localparam logic [6:0] HIGH_CTL_RST = 7'h0d;
    localparam logic [2:0] DIVM_RST = 3'h0;
    typedef enum logic [1:0] {SSWC_OFF, SSWC_NORMAL, SSWC_FULL} sswc_perf_t;
    typedef enum logic [1:0] {SSWC_ACTIVE, SSWC_SLEEP, SSWC_WAKE} sswc_pwr_t;
endpackage : sswc_pkg

// *** hw/sswc_map_if.sv ***
// Interface carrying one side's control bits to the state mapper and the mapped states back.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface sswc_map_if;
    import sswc_pkg::*;
    logic sup_en;
    logic sup_fp;
    logic sup_ret;
    logic mon_en;
    logic mon_fp;
    logic auto_ctl;
    logic deep;
    sswc_perf_t sup_state;
    sswc_perf_t mon_state;
    modport ctrl (output sup_en, sup_fp, sup_ret, mon_en, mon_fp, auto_ctl, deep, input sup_state, mon_state);
    modport mapper (input sup_en, sup_fp, sup_ret, mon_en, mon_fp, auto_ctl, deep, output sup_state, mon_state);
endinterface : sswc_map_if

// *** hw/sswc_state_map.sv ***
// Maps enable, performance, retention and automatic control bits to unit states.
// Assumes the control bits are stable register outputs; result is combinational.
`timescale 1ns/1ps
module sswc_state_map
    import sswc_pkg::*;
(
    sswc_map_if.mapper m
);
    // Supervisor: off when disabled, kept in deep sleep only with retention.
    always_comb begin
        if (!m.sup_en) begin
            m.sup_state = SSWC_OFF;
        end else if (!m.deep) begin
            m.sup_state = m.sup_fp ? SSWC_FULL : SSWC_NORMAL;
        end else if (!m.sup_ret) begin
            m.sup_state = SSWC_OFF;
        end else if (m.auto_ctl) begin
            m.sup_state = m.sup_fp ? SSWC_NORMAL : SSWC_OFF;
        end else begin
            m.sup_state = m.sup_fp ? SSWC_FULL : SSWC_NORMAL;
        end
    end

    // Monitor: retention is implied, automatic control downgrades or shuts it.
    always_comb begin
        if (!m.mon_en) begin
            m.mon_state = SSWC_OFF;
        end else if (!m.deep) begin
            m.mon_state = m.mon_fp ? SSWC_FULL : SSWC_NORMAL;
        end else if (m.auto_ctl) begin
            m.mon_state = m.mon_fp ? SSWC_NORMAL : SSWC_OFF;
        end else begin
            m.mon_state = m.mon_fp ? SSWC_FULL : SSWC_NORMAL;
        end
    end
endmodule : sswc_state_map

// *** hw/sswc_top.sv ***
// Top of the supply supervisor wakeup control block: APB registers, settling delays, wakeup hold-off.
// Assumes a 10 MHz pclk; sleep request, wake and supply-high inputs arrive asynchronously.
`timescale 1ns/1ps
module sswc_top
    import sswc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic deep_sleep_req,
    input wire logic wake_event,
    input wire logic supply_over_limit,
    input wire logic main_clk_from_osc,
    output logic cpu_hold,
    output logic main_clk_half,
    output logic submain_fast_window,
    output logic power_on_reset,
    output logic deep_sleep_active
);
    sswc_map_if low_if ();
    sswc_map_if high_if ();

    logic [5:0] low_ctl_q;
    logic [6:0] high_ctl_q;
    logic [2:0] divm_q;
    logic submain_req_q;
    logic [15:0] low_cnt_q;
    logic [15:0] high_cnt_q;
    logic [15:0] hold_cnt_q;
    logic [15:0] fast_cnt_q;
    logic [2:0] sleep_sync_q;
    logic [2:0] wake_sync_q;
    logic [2:0] ovp_sync_q;
    logic sleep_lvl_q;
    logic wake_lvl_q;
    logic ovp_lvl_q;
    logic por_q;
    sswc_pwr_t pwr_q;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic slow_wake;
    logic low_wr;
    logic high_wr;
    logic wake_rise;

    // Rounded-down cycle count, used for the settling and hold-off delay loads.
    // A set fp bit selects the short delay; normal mode gets the long one.
    function automatic logic [15:0] sswc_delay(input logic fp);
        sswc_delay = fp ? FAST_CYC : SLOW_CYC;
    endfunction : sswc_delay

    // Whether an address belongs to the register map.
    function automatic logic sswc_mapped(input logic [7:0] a);
        sswc_mapped = (a == LOW_CTL_ADDR) || (a == HIGH_CTL_ADDR) || (a == FLAG_ADDR) ||
            (a == CLKDIV_ADDR) || (a == CLKREQ_ADDR) || (a == STATE_ADDR);
    endfunction : sswc_mapped

    // Wiring of the two state mappers.
    assign low_if.sup_en = low_ctl_q[LS_SUP_EN];
    assign low_if.sup_fp = low_ctl_q[LS_SUP_FP];
    assign low_if.sup_ret = low_ctl_q[LS_SUP_RET];
    assign low_if.mon_en = low_ctl_q[LS_MON_EN];
    assign low_if.mon_fp = low_ctl_q[LS_MON_FP];
    assign low_if.auto_ctl = low_ctl_q[LS_AUTO];
    assign low_if.deep = (pwr_q == SSWC_SLEEP);
    assign high_if.sup_en = high_ctl_q[HS_SUP_EN];
    assign high_if.sup_fp = high_ctl_q[HS_SUP_FP];
    assign high_if.sup_ret = high_ctl_q[HS_SUP_RET];
    assign high_if.mon_en = high_ctl_q[HS_MON_EN];
    assign high_if.mon_fp = high_ctl_q[HS_MON_FP];
    assign high_if.auto_ctl = high_ctl_q[HS_AUTO];
    assign high_if.deep = (pwr_q == SSWC_SLEEP);

    sswc_state_map u_low_map (
        .m(low_if.mapper)
    );
    sswc_state_map u_high_map (
        .m(high_if.mapper)
    );

    // APB decode; the access phase completes in its first cycle.
    assign addr_ok = sswc_mapped(paddr);
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !penable && !pwrite;
    assign low_wr = wr_en && (paddr == LOW_CTL_ADDR);
    assign high_wr = wr_en && (paddr == HIGH_CTL_ADDR);

    // Slow wakeup whenever an enabled low-side unit is in normal performance.
    // Either low-side unit in normal mode is enough to need the slow wakeup.
    assign slow_wake = (low_ctl_q[LS_SUP_EN] && !low_ctl_q[LS_SUP_FP]) ||
        (low_ctl_q[LS_MON_EN] && !low_ctl_q[LS_MON_FP]);

    // Wake level qualified by the sleep state; high for one cycle, as the state leaves sleep on it.
    assign wake_rise = wake_lvl_q && (pwr_q == SSWC_SLEEP);

    // Three-stage synchronisers for the asynchronous inputs.
    // The first stage may go metastable, so only the next stage reads it.
    // A pin that toggles faster than the filter settles is simply ignored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_sync_q <= 3'h0;
            wake_sync_q <= 3'h0;
            ovp_sync_q <= 3'h0;
        end else begin
            sleep_sync_q <= {sleep_sync_q[1:0], deep_sleep_req};
            wake_sync_q <= {wake_sync_q[1:0], wake_event};
            ovp_sync_q <= {ovp_sync_q[1:0], supply_over_limit};
        end
    end

    // Levels change only when the second and third stages agree.
    // This rejects a single-cycle glitch at the cost of one more cycle of latency.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_lvl_q <= 1'b0;
            wake_lvl_q <= 1'b0;
            ovp_lvl_q <= 1'b0;
        end else begin
            if (sleep_sync_q[1] == sleep_sync_q[2]) begin
                sleep_lvl_q <= sleep_sync_q[2];
            end
            if (wake_sync_q[1] == wake_sync_q[2]) begin
                wake_lvl_q <= wake_sync_q[2];
            end
            if (ovp_sync_q[1] == ovp_sync_q[2]) begin
                ovp_lvl_q <= ovp_sync_q[2];
            end
        end
    end

    // Control registers written by software.
    // Unmapped addresses never reach these writes, since wr_en already checks the map.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_ctl_q <= LOW_CTL_RST;
            high_ctl_q <= HIGH_CTL_RST;
            divm_q <= DIVM_RST;
            submain_req_q <= 1'b1;
        end else begin
            if (low_wr) begin
                low_ctl_q <= pwdata[5:0];
            end
            if (high_wr) begin
                high_ctl_q <= pwdata[6:0];
            end
            if (wr_en && (paddr == CLKDIV_ADDR)) begin
                divm_q <= pwdata[DIVM_LSB +: 3];
            end
            if (wr_en && (paddr == CLKREQ_ADDR)) begin
                submain_req_q <= pwdata[0];
            end
        end
    end

    // Low-side settling delay, restarted by each write to its control register.
    // The length follows the performance bit being written, not the old one, so a
    // switch to normal mode gets the long delay that lets the core voltage settle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_q <= 16'h0000;
        end else if (low_wr) begin
            low_cnt_q <= sswc_delay(pwdata[LS_SUP_FP]);
        end else if (low_cnt_q != 16'h0000) begin
            low_cnt_q <= low_cnt_q - 16'h0001;
        end
    end

    // High-side settling delay, same treatment.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_cnt_q <= 16'h0000;
        end else if (high_wr) begin
            high_cnt_q <= sswc_delay(pwdata[HS_SUP_FP]);
        end else if (high_cnt_q != 16'h0000) begin
            high_cnt_q <= high_cnt_q - 16'h0001;
        end
    end

    // Power state: sleep entered on request, left on wake, then hold-off runs out.
    // A wake that arrives outside the sleep state is dropped: the unit only
    // leaves sleep on a wake level seen while sleeping.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q <= SSWC_ACTIVE;
        end else begin
            case (pwr_q)
                SSWC_ACTIVE: begin
                    if (sleep_lvl_q) begin
                        pwr_q <= SSWC_SLEEP;
                    end
                end
                SSWC_SLEEP: begin
                    if (wake_lvl_q) begin
                        pwr_q <= SSWC_WAKE;
                    end
                end
                SSWC_WAKE: begin
                    if (hold_cnt_q == 16'h0001) begin
                        pwr_q <= SSWC_ACTIVE;
                    end
                end
                default: begin
                    pwr_q <= SSWC_ACTIVE;
                end
            endcase
        end
    end

    // Execution hold-off: 150 us slow or 2 us fast, loaded at wakeup.
    // While asleep the CPU is held as well, so the hold never drops between the
    // sleep state and the hold-off that follows it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_q <= 16'h0000;
            cpu_hold <= 1'b0;
        end else if (wake_rise) begin
            hold_cnt_q <= sswc_delay(!slow_wake);
            cpu_hold <= 1'b1;
        end else if (hold_cnt_q != 16'h0000) begin
            hold_cnt_q <= hold_cnt_q - 16'h0001;
            cpu_hold <= (hold_cnt_q != 16'h0001);
        end else begin
            cpu_hold <= (pwr_q == SSWC_SLEEP);
        end
    end

    // Sub-main clock is ungated and fast for 6 us after wakeup when it is requested and the main clock runs from the oscillator.
    // The window is only reported; nothing here gates the sub-main clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_cnt_q <= 16'h0000;
            submain_fast_window <= 1'b0;
        end else if (wake_rise && main_clk_from_osc && submain_req_q) begin
            fast_cnt_q <= FASTCLK_CYC;
            submain_fast_window <= 1'b1;
        end else if (fast_cnt_q != 16'h0000) begin
            fast_cnt_q <= fast_cnt_q - 16'h0001;
            submain_fast_window <= (fast_cnt_q != 16'h0001);
        end else begin
            submain_fast_window <= 1'b0;
        end
    end

    // Overvoltage reset, sticky until a flag register write with the FL_POR bit set clears it.
    // An overvoltage event in the same cycle as a clear keeps the request set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_q <= 1'b0;
        end else if (ovp_lvl_q && high_ctl_q[HS_OVP] && high_if.mon_state != SSWC_OFF) begin
            por_q <= 1'b1;
        end else if (wr_en && (paddr == FLAG_ADDR) && pwdata[FL_POR]) begin
            por_q <= 1'b0;
        end
    end

    // Registered status outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_clk_half <= 1'b0;
            power_on_reset <= 1'b0;
            deep_sleep_active <= 1'b0;
        end else begin
            main_clk_half <= (divm_q == DIVM_HALF);
            power_on_reset <= por_q;
            deep_sleep_active <= (pwr_q == SSWC_SLEEP);
        end
    end

    // APB read data and error answer, prepared in the setup cycle.
    // Data are taken in the setup cycle so they stand during the whole access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (rd_en) begin
                case (paddr)
                    LOW_CTL_ADDR: prdata <= {26'h0, low_ctl_q};
                    HIGH_CTL_ADDR: prdata <= {25'h0, high_ctl_q};
                    FLAG_ADDR: prdata <= {28'h0, por_q, slow_wake,
                        (high_cnt_q != 16'h0000), (low_cnt_q != 16'h0000)};
                    CLKDIV_ADDR: prdata <= {29'h0, divm_q};
                    CLKREQ_ADDR: prdata <= {31'h0, submain_req_q};
                    STATE_ADDR: prdata <= {22'h0, pwr_q, high_if.mon_state, high_if.sup_state,
                        low_if.mon_state, low_if.sup_state};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : sswc_top

// *** bench/sswc_top_asserts.sv ***
// Concurrent checks on the supply supervisor wakeup control top ports.
// Assumes a bind onto sswc_top, with one pclk domain and presetn as its reset.
`timescale 1ns/1ps
module sswc_asserts
    import sswc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic supply_over_limit,
    input wire logic cpu_hold,
    input wire logic main_clk_half,
    input wire logic submain_fast_window,
    input wire logic power_on_reset,
    input wire logic deep_sleep_active
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] win_q;
    logic [15:0] hold_q;
    // Run lengths of the fast window and of the hold after wake.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_q <= 16'h0000;
            hold_q <= 16'h0000;
        end else begin
            win_q <= submain_fast_window ? win_q + 16'h0001 : 16'h0000;
            hold_q <= (cpu_hold && !deep_sleep_active) ? hold_q + 16'h0001 : 16'h0000;
        end
    end
    div_half_a: assert property (psel && penable && pready && pwrite && paddr == CLKDIV_ADDR
        |-> ##2 main_clk_half == ($past(pwdata[2:0], 2) == DIVM_HALF)) else $error("main clock half wrong");
    sleep_hold_a: assert property (deep_sleep_active |-> cpu_hold) else $error("no hold in sleep");
    wake_hold_a: assert property ($fell(deep_sleep_active) |-> cpu_hold [*8]) else $error("hold short");
    hold_bound_a: assert property (hold_q <= 16'd1510) else $error("hold too long");
    win_bound_a: assert property (win_q <= FASTCLK_CYC) else $error("window too long");
    win_run_a: assert property ($rose(submain_fast_window) |-> submain_fast_window [*8])
        else $error("window too short");
    por_keep_a: assert property (power_on_reset && !(psel && penable && pwrite && paddr == FLAG_ADDR)
        && !$past(psel && penable && pwrite && paddr == FLAG_ADDR) |=> power_on_reset)
        else $error("reset request lost");
    por_cause_a: assert property (!supply_over_limit [*6] |=> !$rose(power_on_reset))
        else $error("reset request without cause");
    low_dly_a: assert property ((psel && penable && pwrite && paddr == LOW_CTL_ADDR) ##[1:4]
        (psel && penable && !pwrite && paddr == FLAG_ADDR) |-> prdata[FL_LOW_DLY]) else $error("low flag clear");
    high_dly_a: assert property ((psel && penable && pwrite && paddr == HIGH_CTL_ADDR) ##[1:4]
        (psel && penable && !pwrite && paddr == FLAG_ADDR) |-> prdata[FL_HIGH_DLY]) else $error("high flag clear");
endmodule : sswc_asserts
bind sswc_top sswc_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .supply_over_limit(supply_over_limit), .cpu_hold(cpu_hold), .main_clk_half(main_clk_half),
    .submain_fast_window(submain_fast_window), .power_on_reset(power_on_reset),
    .deep_sleep_active(deep_sleep_active));

// *** bench/supply_supervisor_wakeup_control_bench.sv ***
// Self-checking bench for the supply supervisor wakeup control block.
// Assumes a 10 MHz pclk; the bench drives every input port of sswc_top itself.
`timescale 1ns/1ps
module supply_supervisor_wakeup_control_bench;
    import sswc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, deep_sleep_req, wake_event, supply_over_limit, main_clk_from_osc;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic pready, pslverr, rerr, cpu_hold, main_clk_half, submain_fast_window, power_on_reset, deep_sleep_active;
    logic [31:0] rst_val [7] = '{32'h0d, 32'h0d, 32'h4, 32'h0, 32'h1, 32'h55, 32'h0};
    logic [5:0] lcorn [4] = '{6'h00, 6'h1b, 6'h3f, 6'h0d};
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    sswc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .deep_sleep_req(deep_sleep_req), .wake_event(wake_event), .supply_over_limit(supply_over_limit),
        .main_clk_from_osc(main_clk_from_osc), .cpu_hold(cpu_hold), .main_clk_half(main_clk_half),
        .submain_fast_window(submain_fast_window), .power_on_reset(power_on_reset),
        .deep_sleep_active(deep_sleep_active));
    // Free-running 10 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Ends a hung run after more than twice the expected length.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            miscompares++;
            complete_run();
        end
    end
    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    // Compares one result and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; holds the request until pready is seen at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Polls the flags until both settling delays have run out.
    task automatic wait_flags(output int el);
        int t0;
        t0 = cycles;
        do apb(1'b0, FLAG_ADDR, 32'h0); while (rdata[1:0] !== 2'b00);
        el = cycles - t0;
    endtask : wait_flags
    // Expected state of one unit.
    function automatic logic [1:0] unit(input logic en, input logic fp, input logic ret, input logic au,
        input logic dp);
        if (!en || (dp && !ret)) return 2'd0;
        if (dp && au) return fp ? 2'd1 : 2'd0;
        return fp ? 2'd2 : 2'd1;
    endfunction : unit
    // Expected state word; monitors always retain.
    function automatic logic [31:0] exp_state(input logic [5:0] l, input logic [6:0] h, input logic dp);
        return {22'h0, 1'b0, dp, unit(h[HS_MON_EN], h[HS_MON_FP], 1'b1, h[HS_AUTO], dp),
            unit(h[HS_SUP_EN], h[HS_SUP_FP], h[HS_SUP_RET], h[HS_AUTO], dp),
            unit(l[LS_MON_EN], l[LS_MON_FP], 1'b1, l[LS_AUTO], dp),
            unit(l[LS_SUP_EN], l[LS_SUP_FP], l[LS_SUP_RET], l[LS_AUTO], dp)};
    endfunction : exp_state
    // Main sequence: reset, registers, delays, sleep and wake, overvoltage.
    initial begin
        logic [5:0] lc;
        logic [6:0] hc;
        logic rq, osc, slow;
        int el, hn, wn, eh;
        {psel, penable, pwrite, deep_sleep_req, wake_event, supply_over_limit, main_clk_from_osc} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        el = $urandom(32'ha3f6d972);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rdata, rst_val[i]);
            chk(32'(rerr), 32'(i == 6));
        end
        for (int v = 0; v < 8; v++) begin
            apb(1'b1, CLKDIV_ADDR, 32'(v));
            repeat (2) @(posedge pclk);
            chk(32'(main_clk_half), 32'(3'(v) == DIVM_HALF));
        end
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, LOW_CTL_ADDR, k ? 32'h03 : 32'h01);
            apb(1'b0, FLAG_ADDR, 32'h0);
            chk(32'(rdata[FL_LOW_DLY]), 32'h1);
            if (k == 0) begin
                repeat (700) @(posedge pclk);
                apb(1'b1, LOW_CTL_ADDR, 32'h01);
            end
            wait_flags(el);
            eh = k ? FAST_CYC : SLOW_CYC;
            chk(32'(el >= eh - 6 && el <= eh + 8), 32'h1);
        end
        for (int i = 0; i < 10; i++) begin
            lc = (i < 4) ? lcorn[i] : 6'($urandom);
            hc = 7'($urandom) & 7'h3f;
            rq = (i != 3);
            osc = 1'($urandom);
            slow = (lc[LS_SUP_EN] & !lc[LS_SUP_FP]) | (lc[LS_MON_EN] & !lc[LS_MON_FP]);
            apb(1'b1, LOW_CTL_ADDR, 32'(lc));
            apb(1'b1, HIGH_CTL_ADDR, 32'(hc));
            apb(1'b0, FLAG_ADDR, 32'h0);
            chk(32'(rdata[FL_HIGH_DLY]), 32'h1);
            chk(32'(rdata[FL_WAKE_SLOW]), 32'(slow));
            apb(1'b1, CLKREQ_ADDR, 32'(rq));
            main_clk_from_osc <= osc;
            wait_flags(el);
            apb(1'b0, STATE_ADDR, 32'h0);
            chk(rdata, exp_state(lc, hc, 1'b0));
            apb(1'b1, CLKDIV_ADDR, 32'(DIVM_HALF));
            deep_sleep_req <= 1'b1;
            wait (deep_sleep_active === 1'b1);
            @(posedge pclk);
            chk(32'(cpu_hold), 32'h1);
            chk(32'(main_clk_half), 32'h1);
            apb(1'b0, STATE_ADDR, 32'h0);
            chk(rdata, exp_state(lc, hc, 1'b1));
            deep_sleep_req <= 1'b0;
            wake_event <= 1'b1;
            hn = 0;
            wn = 0;
            repeat (1600) begin
                @(posedge pclk);
                hn += int'(cpu_hold === 1'b1);
                wn += int'(submain_fast_window === 1'b1);
            end
            wake_event <= 1'b0;
            apb(1'b1, CLKDIV_ADDR, 32'h0);
            eh = slow ? SLOW_CYC : FAST_CYC;
            chk(32'(hn >= eh && hn <= eh + 8), 32'h1);
            chk(32'(wn), (osc && rq) ? 32'(FASTCLK_CYC) : 32'h0);
        end
        supply_over_limit <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(32'(power_on_reset), 32'h0);
        apb(1'b1, HIGH_CTL_ADDR, 32'h48);
        repeat (10) @(posedge pclk);
        chk(32'(power_on_reset), 32'h1);
        supply_over_limit <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(1'b0, FLAG_ADDR, 32'h0);
        chk(32'(rdata[FL_POR]), 32'h1);
        apb(1'b1, FLAG_ADDR, 32'h08);
        repeat (2) @(posedge pclk);
        chk(32'(power_on_reset), 32'h0);
        complete_run();
    end
endmodule : supply_supervisor_wakeup_control_bench
